// File: sacp_ctrl.sv
// Conversion, power mode and serial output control
module sacp_ctrl
   import sacp_pkg::*;
#(
   parameter int RES            = RES_BITS,
   parameter int REF_SETTLE_CYC = REF_SETTLE_CYC_DEF
) (
   input  wire logic           i_clk,
   input  wire logic           i_nrst,
   input  wire logic           i_ce,
   input  wire logic           i_conversion_trigger_trigger,
   input  wire logic           i_sclk,
   input  wire logic           i_shutdown_n,
   input  wire logic           i_cmp_high,
   output logic                o_dout,
   output logic                o_dout_oe,
   output logic                o_ref_ready,
   output logic [RES-1:0]      o_dac_code,
   output logic                o_sampling,
   output logic                o_power_down
);

   localparam int FRAME  = RES + 1;
   localparam int BCNT_W = $clog2(FRAME + 1);
   localparam int REF_W  = $clog2(REF_SETTLE_CYC + 1);
   localparam int A_WAKE = NAP_WAKE_CYC;

   //==============================================================
   // Pin synchronisers
   logic conversion_trigger_m, conversion_trigger_s, conversion_trigger_d;
   logic sclk_m, sclk_s, sclk_d;
   logic shutdown_input_n_m, shutdown_input_n_s;
   logic cmp_m,  cmp_s;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         {conversion_trigger_m, conversion_trigger_s, conversion_trigger_d} <= 3'h0;
         {sclk_m, sclk_s, sclk_d} <= 3'h0;
         {shutdown_input_n_m, shutdown_input_n_s}         <= 2'h3; // Idle level, so no false shutdown after reset
         {cmp_m, cmp_s}           <= 2'h0;
      end else if (i_ce) begin
         conversion_trigger_m <= i_conversion_trigger_trigger;
         conversion_trigger_s <= conversion_trigger_m;
         conversion_trigger_d <= conversion_trigger_s;
         sclk_m <= i_sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         shutdown_input_n_m <= i_shutdown_n;
         shutdown_input_n_s <= shutdown_input_n_m;
         cmp_m  <= i_cmp_high;
         cmp_s  <= cmp_m;
      end
   end

   logic conversion_trigger_rise, sclk_rise, sclk_fall;
   assign conversion_trigger_rise = conversion_trigger_s & ~conversion_trigger_d;
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;

   //==============================================================
   // Control state
   sacp_state_t        st_reg, st_next;
   logic [2:0]         pulse_reg, pulse_next;
   logic [RES-1:0]     sar_reg, sar_next;
   logic [RES-1:0]     trial_reg, trial_next;
   logic [CNT_W-1:0]   cnt_reg, cnt_next;
   logic [CNT_W-1:0]   gap_reg, gap_next;
   logic [CNT_W-1:0]   hi_reg, hi_next;
   logic               badgap_reg, badgap_next;
   logic [REF_W-1:0]   rcnt_reg, rcnt_next;
   logic               ref_reg, ref_next;
   logic [RES-1:0]     dac_reg, dac_next;
   logic               samp_reg, samp_next;
   logic               pdn_reg, pdn_next;
   logic               push;
   logic               buf_in_ready;
   logic               req_light, req_deep, req_ok;

   assign req_light = conversion_trigger_rise & ~sclk_s & (pulse_reg == LIGHT_PULSES - 3'h1);
   assign req_deep  = conversion_trigger_rise & ~sclk_s & (pulse_reg == DEEP_PULSES - 3'h1);
   assign req_ok    = (st_reg != ST_SHUTDOWN_INPUT_N) && (st_reg != ST_WAKE) && (st_reg != ST_DEEP);

   always_comb begin
      st_next     = st_reg;
      pulse_next  = pulse_reg;
      sar_next    = sar_reg;
      trial_next  = trial_reg;
      cnt_next    = cnt_reg;
      badgap_next = badgap_reg;
      rcnt_next   = rcnt_reg;
      ref_next    = ref_reg;
      push        = 1'b0;
      gap_next    = (gap_reg < CNT_W'(SB_GAP_CYC)) ? gap_reg + 1'b1 : gap_reg;
      hi_next     = !sclk_s ? '0 :
                    (hi_reg < CNT_W'(WAKE_PW_CYC)) ? hi_reg + 1'b1 : hi_reg;
      // Any clock high ends a standby pulse sequence
      if (sclk_s)
         pulse_next = 3'h0;
      else if (conversion_trigger_rise && pulse_reg != DEEP_PULSES)
         pulse_next = pulse_reg + 3'h1;

      case (st_reg)
         ST_IDLE: begin
            if (conversion_trigger_rise && pulse_reg == 3'h0) begin
               st_next    = ST_CONVERSION_TRIGGER;
               sar_next   = '0;
               trial_next = {1'b1, {(RES - 1){1'b0}}};
            end
         end
         ST_CONVERSION_TRIGGER: begin
            // Further trigger edges do not restart the conversion; a standby request below can still end it
            if (trial_reg == '0) begin
               // Full buffer holds the result back rather than lose it
               if (buf_in_ready) begin
                  push     = 1'b1;
                  st_next  = ST_RECOVER;
                  cnt_next = CNT_W'(CONVERSION_TRIGGER_GAP_CYC - 1);
               end
            end else if (sclk_rise) begin
               if (cmp_s)
                  sar_next = sar_reg | trial_reg;
               trial_next = trial_reg >> 1;
            end
         end
         ST_RECOVER, ST_WAKE: begin
            if (cnt_reg == '0)
               st_next = ST_IDLE;
            else
               cnt_next = cnt_reg - 1'b1;
         end
         ST_LIGHT, ST_DEEP: begin
            if (sclk_rise && gap_reg < CNT_W'(SB_GAP_CYC))
               badgap_next = 1'b1;
            if (sclk_fall) begin
               badgap_next = 1'b0;
               cnt_next    = CNT_W'(NAP_WAKE_CYC - 1);
               if (badgap_reg || hi_reg < CNT_W'(WAKE_PW_CYC))
                  st_next = ST_STUCK;
               else
                  st_next = ST_WAKE;
            end
         end
         ST_SHUTDOWN_INPUT_N: begin
            if (shutdown_input_n_s)
               st_next = ST_IDLE;
         end
         default: begin
            // Stuck: conversions ignored until a light request
         end
      endcase

      if (req_ok && (req_deep || req_light)) begin
         st_next     = req_deep ? ST_DEEP : ST_LIGHT;
         gap_next    = '0;
         badgap_next = 1'b0;
      end
      if (!shutdown_input_n_s)
         st_next = ST_SHUTDOWN_INPUT_N;

      // Reference settles only while powered
      if (st_reg == ST_SHUTDOWN_INPUT_N || st_reg == ST_DEEP || !shutdown_input_n_s) begin
         ref_next  = 1'b0;
         rcnt_next = '0;
      end else if (!ref_reg) begin
         rcnt_next = rcnt_reg + 1'b1;
         if (rcnt_reg == REF_W'(REF_SETTLE_CYC - 1))
            ref_next = 1'b1;
      end

      dac_next  = sar_next | trial_next;
      samp_next = (st_next != ST_CONVERSION_TRIGGER);
      pdn_next  = (st_next == ST_DEEP) || (st_next == ST_SHUTDOWN_INPUT_N);
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_reg     <= ST_IDLE;
         pulse_reg  <= 3'h0;
         sar_reg    <= '0;
         trial_reg  <= '0;
         cnt_reg    <= '0;
         gap_reg    <= '0;
         hi_reg     <= '0;
         badgap_reg <= 1'b0;
         rcnt_reg   <= '0;
         ref_reg    <= 1'b0;
         dac_reg    <= '0;
         samp_reg   <= 1'b1;
         pdn_reg    <= 1'b0;
      end else if (i_ce) begin
         st_reg     <= st_next;
         pulse_reg  <= pulse_next;
         sar_reg    <= sar_next;
         trial_reg  <= trial_next;
         cnt_reg    <= cnt_next;
         gap_reg    <= gap_next;
         hi_reg     <= hi_next;
         badgap_reg <= badgap_next;
         rcnt_reg   <= rcnt_next;
         ref_reg    <= ref_next;
         dac_reg    <= dac_next;
         samp_reg   <= samp_next;
         pdn_reg    <= pdn_next;
      end
   end

   //==============================================================
   // Two-entry result buffer and serial frame
   logic [RES-1:0]    mem_reg [BUF_DEPTH];
   logic [RES-1:0]    mem_next [BUF_DEPTH];
   logic              wp_reg, wp_next, rp_reg, rp_next;
   logic [1:0]        bcnt_reg, bcnt_next;
   logic              fr_reg, fr_next;
   logic [FRAME-1:0]  sh_reg, sh_next;
   logic [BCNT_W-1:0] bit_reg, bit_next;
   logic              dout_reg, dout_next;
   logic              oe_reg, oe_next;
   logic              out_valid, pop;

   assign buf_in_ready = (bcnt_reg != 2'(BUF_DEPTH));
   assign out_valid    = (bcnt_reg != 2'h0);
   assign pop          = out_valid & ~fr_reg;

   always_comb begin
      mem_next  = mem_reg;
      wp_next   = wp_reg;
      rp_next   = rp_reg;
      bcnt_next = bcnt_reg;
      fr_next   = fr_reg;
      sh_next   = sh_reg;
      bit_next  = bit_reg;
      dout_next = dout_reg;
      oe_next   = oe_reg;
      if (push) begin
         mem_next[wp_reg] = sar_reg;
         wp_next          = ~wp_reg;
      end
      if (pop) begin
         rp_next  = ~rp_reg;
         sh_next  = {ref_reg, mem_reg[rp_reg]};
         fr_next  = 1'b1;
         bit_next = '0;
      end else if (fr_reg && sclk_rise) begin
         if (bit_reg != BCNT_W'(FRAME)) begin
            dout_next = sh_reg[FRAME-1];
            sh_next   = sh_reg << 1;
            oe_next   = 1'b1;
            bit_next  = bit_reg + 1'b1;
         end else begin
            oe_next = 1'b0;
            fr_next = 1'b0;
         end
      end
      bcnt_next = bcnt_reg + {1'b0, push} - {1'b0, pop};
      if (!shutdown_input_n_s) begin
         fr_next   = 1'b0;
         oe_next   = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         mem_reg  <= '{default: '0};
         wp_reg   <= 1'b0;
         rp_reg   <= 1'b0;
         bcnt_reg <= 2'h0;
         fr_reg   <= 1'b0;
         sh_reg   <= '0;
         bit_reg  <= '0;
         dout_reg <= 1'b0;
         oe_reg   <= 1'b0;
      end else if (i_ce) begin
         mem_reg  <= mem_next;
         wp_reg   <= wp_next;
         rp_reg   <= rp_next;
         bcnt_reg <= bcnt_next;
         fr_reg   <= fr_next;
         sh_reg   <= sh_next;
         bit_reg  <= bit_next;
         dout_reg <= dout_next;
         oe_reg   <= oe_next;
      end
   end

   assign o_dout       = dout_reg;
   assign o_dout_oe    = oe_reg;
   assign o_ref_ready  = ref_reg;
   assign o_dac_code   = dac_reg;
   assign o_sampling   = samp_reg;
   assign o_power_down = pdn_reg;

   //==============================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst || !i_ce);

   property p_start;
      st_reg == ST_IDLE && conversion_trigger_rise && pulse_reg == 3'h0 && shutdown_input_n_s
         |=> st_reg == ST_CONVERSION_TRIGGER && sar_reg == '0;
   endproperty
   a_start: assert property (p_start) else $error("trigger did not start");
   property p_light;
      req_ok && req_light && shutdown_input_n_s |=> st_reg == ST_LIGHT;
   endproperty
   a_light: assert property (p_light) else $error("no light standby");
   property p_deep;
      req_ok && req_deep && shutdown_input_n_s |=> st_reg == ST_DEEP ##1 !o_ref_ready;
   endproperty
   a_deep: assert property (p_deep) else $error("no deep standby");
   property p_shutdown_input_n;
      !shutdown_input_n_s |=> st_reg == ST_SHUTDOWN_INPUT_N && !o_ref_ready && !o_dout_oe;
   endproperty
   a_shutdown_input_n: assert property (p_shutdown_input_n) else $error("shutdown not taken");
   property p_wake;
      st_reg == ST_LIGHT && sclk_fall && shutdown_input_n_s && !badgap_reg && !conversion_trigger_rise
         && hi_reg >= CNT_W'(WAKE_PW_CYC) |=> st_reg == ST_WAKE;
   endproperty
   a_wake: assert property (p_wake) else $error("valid pulse did not wake");
   property p_wake_time;
      $rose(st_reg == ST_WAKE) |-> ##A_WAKE (st_reg == ST_IDLE || st_reg == ST_SHUTDOWN_INPUT_N);
   endproperty
   a_wake_time: assert property (p_wake_time) else $error("wake delay wrong");

   property p_stuck;
      st_reg == ST_STUCK && conversion_trigger_rise && !req_light |=> st_reg != ST_CONVERSION_TRIGGER;
   endproperty
   a_stuck: assert property (p_stuck) else $error("stuck state converted");

   property p_frame_end;
      fr_reg && sclk_rise && bit_reg == BCNT_W'(FRAME) && !pop |=> !o_dout_oe;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("output not released");

   c_conversion_trigger:  cover property (st_reg == ST_CONVERSION_TRIGGER ##1 st_reg == ST_RECOVER);
   c_light: cover property (st_reg == ST_LIGHT ##1 st_reg == ST_WAKE);
   c_stuck: cover property (st_reg == ST_STUCK ##1 st_reg == ST_LIGHT);
   c_full:  cover property (!buf_in_ready);

endmodule : sacp_ctrl

// File: sacp_pkg.sv
// Constants and types for the serial converter control block
//==============================================================
// Contract
// - A rising edge on the conversion trigger starts a new conversion.
// - With the serial clock low, two trigger pulses enter light standby and four enter deep standby.
// - A serial clock pulse of at least 60 ns wakes the device from either standby.
// - While the shutdown input is low the device is shut down and the ready flag is low.
// - The result leaves bit-serially, one bit per rising serial clock edge.
// - After a light standby wake the device is ready to convert after 350 ns.
// - A bad wake pulse or wake spacing blocks conversions until a light standby request.
// - Conversions run at up to 200 kHz, one bit decision per serial clock.
// - Each output word carries the reference ready flag.
// - A running conversion is never restarted, and the result register clears at start.
// - After deep standby or shutdown the ready flag stays low for 3 ms.
package sacp_pkg;

   //==============================================================
   // Sizes
   localparam int RES_BITS  = 12;
   localparam int BUF_DEPTH = 2;
   localparam int CNT_W     = 5;

   localparam logic [2:0] LIGHT_PULSES = 3'h2;
   localparam logic [2:0] DEEP_PULSES  = 3'h4;

   //==============================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int WAKE_PW_NS    = 60;
   localparam int WAKE_PW_CYC   = (WAKE_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SB_GAP_NS     = 50;
   localparam int SB_GAP_CYC    = (SB_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NAP_WAKE_NS   = 350;
   localparam int NAP_WAKE_CYC  = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONVERSION_TRIGGER_GAP_NS   = 550;
   localparam int CONVERSION_TRIGGER_GAP_CYC  = (CONVERSION_TRIGGER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REF_SETTLE_MS = 3;
   localparam int REF_SETTLE_CYC_DEF = REF_SETTLE_MS * 1000000 / CLK_PERIOD_NS;

   //==============================================================
   // Control states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CONVERSION_TRIGGER,
      ST_RECOVER,
      ST_LIGHT,
      ST_DEEP,
      ST_WAKE,
      ST_STUCK,
      ST_SHUTDOWN_INPUT_N
   } sacp_state_t;

endpackage : sacp_pkg

// File: sacp_host.sv
// Host serial port model: drives trigger and serial clock, reads the data pin
module sacp_host (
   input  wire logic i_clk,
   input  wire logic i_dout,
   input  wire logic i_dout_oe,
   output logic      o_sclk,
   output logic      o_conversion_trigger_trigger
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_sclk = 1'b0;
      o_conversion_trigger_trigger = 1'b0;
   end

   //==============================================================
   // Pin timing
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask : tick

   // Clock stands low between pulses; sampled just before the next rise
   task automatic sclk_cycle(output logic d, output logic oe);
      o_sclk = 1'b1;
      tick(4);
      o_sclk = 1'b0;
      tick(3);
      d = i_dout;
      oe = i_dout_oe;
      tick(1);
   endtask : sclk_cycle

   // High for hi clocks of 25 ns, so it drops before the first bit decision
   task automatic trig_pulse(input int hi);
      o_conversion_trigger_trigger = 1'b1;
      tick(hi);
      o_conversion_trigger_trigger = 1'b0;
      tick(4);
   endtask : trig_pulse

   //==============================================================
   // Requests
   task automatic standby(input int n);
      repeat (n) trig_pulse(4);
   endtask : standby

   task automatic wake(input int w);
      o_sclk = 1'b1;
      tick(w);
      o_sclk = 1'b0;
      tick(16);
   endtask : wake

   // Extra trigger after rise trig_at tries to restart a running conversion
   task automatic convert(input int trig_at, output logic [12:0] word,
                          output logic [12:0] oe_v, output logic oe_end);
      logic d;
      logic oe;
      trig_pulse(4);
      for (int k = 1; k <= 12; k++) begin
         sclk_cycle(d, oe);
         if (k == trig_at) begin
            trig_pulse(3);
         end
      end
      tick(8);
      for (int k = 0; k < 13; k++) begin
         sclk_cycle(d, oe);
         word = {word[11:0], d};
         oe_v = {oe_v[11:0], oe};
      end
      sclk_cycle(d, oe_end);
   endtask : convert

endmodule : sacp_host

// File: test_sacp_ctrl.sv
// Self-checking bench for the converter control block
module test_sacp_ctrl;
   import sacp_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SETTLE = 50;
   localparam int LIMIT  = 6000;

   typedef struct packed {
      logic [11:0] vin;
      int          trig_at;
      logic [12:0] exp_word;
   } sacp_row_t;

   logic          i_clk = 1'b0;
   logic          i_nrst = 1'b0;
   logic          i_shutdown_n = 1'b1;
   logic          ce = 1'b1;
   logic [11:0]   vin = 12'h000;
   logic          last_bit = 1'b0;
   logic          pin_dout;
   logic          sclk;
   logic          trig;
   logic          cmp;
   logic          o_dout;
   logic          o_dout_oe;
   logic          o_ref_ready;
   logic [11:0]   o_dac_code;
   logic          o_sampling;
   logic          o_power_down;
   int            mismatches = 0;
   int            n_checks = 0;
   int            cycles = 0;
   sacp_row_t     rows [5] = '{'{12'h000, 0, 13'h1000}, '{12'hFFF, 0, 13'h1FFF},
                               '{12'hA5A, 0, 13'h1A5A}, '{12'h801, 0, 13'h1801},
                               '{12'h3C3, 6, 13'h13C3}};

   always #12.5 i_clk = ~i_clk;

   // Comparator stands in for the analog core
   assign cmp = (o_dac_code <= vin);
   // Released pin shows the inverse of its last bit, not a stale value
   always @(posedge i_clk) if (o_dout_oe) last_bit <= o_dout;
   assign pin_dout = o_dout_oe ? o_dout : ~last_bit;

   sacp_ctrl #(.REF_SETTLE_CYC(SETTLE)) sacp_ctrl_inst (
      .i_clk          (i_clk),
      .i_nrst         (i_nrst),
      .i_ce           (ce),
      .i_conversion_trigger_trigger (trig),
      .i_sclk         (sclk),
      .i_shutdown_n   (i_shutdown_n),
      .i_cmp_high     (cmp),
      .o_dout         (o_dout),
      .o_dout_oe      (o_dout_oe),
      .o_ref_ready    (o_ref_ready),
      .o_dac_code     (o_dac_code),
      .o_sampling     (o_sampling),
      .o_power_down   (o_power_down)
   );

   sacp_host sacp_host_inst (
      .i_clk          (i_clk),
      .i_dout         (pin_dout),
      .i_dout_oe      (o_dout_oe),
      .o_sclk         (sclk),
      .o_conversion_trigger_trigger (trig)
   );

   //==============================================================
   // Checking
   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // Zero exp_oe means the request must be ignored
   task automatic run(input logic [11:0] x, input logic [12:0] exp_oe);
      logic [12:0] w;
      logic [12:0] v;
      logic        e;
      vin = x;
      sacp_host_inst.convert(0, w, v, e);
      check(v, exp_oe);
      if (exp_oe !== 13'h0000) begin
         check(w, {1'b1, x});
      end
   endtask : run

   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         finish_test();
      end
   end

   //==============================================================
   // Scenarios
   initial begin
      logic [12:0] w;
      logic [12:0] v;
      logic        e;
      repeat (16) @(posedge i_clk);
      #2;
      check({9'h0, o_dout_oe, o_ref_ready, o_sampling, o_power_down}, 13'h0002);
      i_nrst = 1'b1;
      sacp_host_inst.tick(2);
      check({11'h0, o_power_down, o_sampling}, 13'h0001);
      sacp_host_inst.tick(SETTLE + 8);
      check({12'h0, o_ref_ready}, 13'h0001);
      foreach (rows[i]) begin
         vin = rows[i].vin;
         sacp_host_inst.convert(rows[i].trig_at, w, v, e);
         check(w, rows[i].exp_word);
         check(v, 13'h1FFF);
         check({12'h0, e}, 13'h0000);
      end
      // First pulse starts a conversion, second turns it into light standby
      sacp_host_inst.trig_pulse(4);
      check({12'h0, o_sampling}, 13'h0000);
      check({1'b0, o_dac_code}, 13'h0800);
      sacp_host_inst.standby(1);
      check({12'h0, o_power_down}, 13'h0000);
      sacp_host_inst.wake(4);
      run(12'h5A5, 13'h1FFF);
      // Too short a wake pulse locks out conversions until a light request
      sacp_host_inst.standby(2);
      sacp_host_inst.wake(1);
      run(12'h0F0, 13'h0000);
      sacp_host_inst.standby(2);
      sacp_host_inst.wake(4);
      run(12'h0F0, 13'h1FFF);
      sacp_host_inst.standby(4);
      check({11'h0, o_power_down, o_ref_ready}, 13'h0002);
      sacp_host_inst.wake(4);
      check({12'h0, o_ref_ready}, 13'h0000);
      sacp_host_inst.tick(SETTLE);
      run(12'h7FE, 13'h1FFF);
      i_shutdown_n = 1'b0;
      sacp_host_inst.tick(6);
      check({10'h0, o_dout_oe, o_ref_ready, o_power_down}, 13'h0001);
      i_shutdown_n = 1'b1;
      sacp_host_inst.tick(30);
      check({12'h0, o_ref_ready}, 13'h0000);
      // Clock enable low must freeze the settle count
      ce = 1'b0;
      sacp_host_inst.tick(100);
      check({12'h0, o_ref_ready}, 13'h0000);
      ce = 1'b1;
      sacp_host_inst.tick(40);
      check({12'h0, o_ref_ready}, 13'h0001);
      run(12'h001, 13'h1FFF);
      finish_test();
   end

endmodule : test_sacp_ctrl
